// File: stwf_top.sv
// status word register with flag unit, save/restore and apb access
`timescale 1ns/1ps
// Overview of operation
// RQ1 - 16-bit word, read/written as two bytes, single flags set/cleared/tested.
// RQ2 - Push word on vectored interrupt or break; pop on interrupt returns.
// RQ3 - Copy word to context save pair; restore on context-switch returns.
// RQ4 - Reset clears all bits: bank zero, interrupts disabled.
// RQ5 - Bit 1 of low half written zero; high low nibble undefined on read.
// RQ6 - High: user flag 7, bank 6-4. Low: S Z REGISTER_SET_SELECT AC IE PV 7-2, CY 0.
// RQ7 - Carry takes arithmetic carry/borrow, shifted-out bit, and acts as bit accumulator.
// RQ8 - Parity set for even ones; 16-bit shifts count only low byte.
// RQ9 - Arithmetic overflow is carry out of MSB xor carry into MSB.
// RQ10 - Interrupt enable low: only non-maskable and unmasked macro service accepted.
// RQ11 - Interrupt enable high: maskable acceptance by own mask and priority.
// RQ12 - Enable instruction sets flag; disable instruction or acknowledge clears it.
// RQ13 - Half carry set on carry out of or borrow into bit 3.
// RQ14 - Zero flag set for zero result, cleared otherwise.
// RQ15 - Sign flag copies the result's most significant bit.
// RQ16 - Three-bit bank selector picks bank n; bank instruction loads it.
// RQ17 - User flag is software owned with no hardware effect.
// RQ18 - Select low: A R1, X R0, B R3, C R2, pairs 0 and 1.
// RQ19 - Select high: A R5, X R4, B R7, C R6, pairs 2 and 3.
// RQ20 - Remap applies only to named, implied and index operands.
// RQ21 - Software keeps register-set select at zero except for legacy code.
// RQ22 - Branches test carry, parity/overflow, zero and sign directly.
// RQ23 - 16-bit overflow from bit 15 carries; unaffected flags keep values.
module stwf_top (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // flag unit
  input  wire logic        FLAG_UPD,
  input  wire logic [1:0]  FLAG_KIND,
  input  wire logic [4:0]  FLAG_AFFECT,
  input  wire logic        OP_WIDE,
  input  wire logic        OP_SUB,
  input  wire logic        OP_CIN,
  input  wire logic [15:0] OP_A,
  input  wire logic [15:0] OP_B,
  input  wire logic [15:0] RESULT_IN,
  input  wire logic        SHIFT_OUT,
  output logic      [15:0] SUM_OUT,
  // single-bit operations
  input  wire logic [1:0]  BIT_OP,
  input  wire logic [3:0]  BIT_SEL,
  input  wire logic        BIT_VAL,
  output logic             BIT_TEST,
  // instructions
  input  wire logic        EI_EXEC,
  input  wire logic        DI_EXEC,
  input  wire logic        BANK_SEL_EXEC,
  input  wire logic [2:0]  BANK_NUM,
  // save and restore
  input  wire logic        INT_ACK,
  input  wire logic        BRK_EXEC,
  input  wire logic        CTX_SAVE,
  input  wire logic        POP_VALID,
  input  wire logic [15:0] POP_DATA,
  input  wire logic        CTX_RESTORE,
  input  wire logic [15:0] CTX_DATA,
  output logic      [15:0] SAVE_WORD,
  output logic             SAVE_STROBE,
  output logic             SAVE_TO_CTX,
  // interrupt gating
  input  wire logic        NMI_REQ,
  input  wire logic        MACRO_REQ,
  input  wire logic        MASK_REQ,
  input  wire logic        MASK_FLAG,
  input  wire logic        PRIO_OK,
  output logic             INT_ACCEPT,
  // register remap
  input  wire logic        REMAP_APPLIES,
  input  wire logic [2:0]  REG_NAME,
  input  wire logic [3:0]  REG_ABS,
  output logic      [3:0]  REG_NUM,
  // status
  output logic      [15:0] STATUS_WORD,
  output logic      [2:0]  BANK,
  output logic             REGISTER_SET_SELECT,
  output logic             FLAG_CARRY,
  output logic             FLAG_PV,
  output logic             FLAG_ZERO,
  output logic             FLAG_SIGN
);

  stwf_pkg::stwf_state_t r_q;
  stwf_pkg::stwf_state_t r_d;

  logic        setup;
  logic        access;
  logic        hit_high;
  logic        hit_low;
  logic [15:0] bx;
  logic        cx;
  logic [16:0] sum16;
  logic [8:0]  sum8;
  logic [15:0] res;
  logic        res_msb;
  logic        res_zero;
  logic        ar_carry;
  logic        ar_ovf;
  logic        ar_half;
  logic        par_even;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign setup    = PSEL && !PENABLE;
  assign access   = PSEL && PENABLE && CE;
  assign hit_high = (PADDR == stwf_pkg::ADDR_HIGH);
  assign hit_low  = (PADDR == stwf_pkg::ADDR_LOW);
  assign PREADY   = CE;
  assign PRDATA   = r_q.rdata;
  assign PSLVERR  = PSEL && PENABLE && r_q.slverr;

  // ----------------------------------------------------------------
  // arithmetic: subtract as add of complement, borrow = not carry
  // ----------------------------------------------------------------
  assign bx      = OP_SUB ? ~OP_B : OP_B;
  assign cx      = OP_SUB ? ~OP_CIN : OP_CIN;
  assign sum16   = {1'b0, OP_A} + {1'b0, bx} + {16'h0000, cx};
  assign sum8    = {1'b0, OP_A[7:0]} + {1'b0, bx[7:0]} + {8'h00, cx};
  assign SUM_OUT = OP_WIDE ? sum16[15:0] : {8'h00, sum8[7:0]};
  assign res     = (FLAG_KIND == stwf_pkg::KIND_ARITH) ? SUM_OUT : RESULT_IN;
  assign res_msb = OP_WIDE ? res[15] : res[7];
  assign res_zero = OP_WIDE ? (res == 16'h0000) : (res[7:0] == 8'h00); // RQ14
  assign ar_carry = (OP_WIDE ? sum16[16] : sum8[8]) ^ OP_SUB; // RQ7
  assign ar_ovf  = OP_WIDE ? (sum16[16] ^ (OP_A[15] ^ bx[15] ^ sum16[15])) // RQ23
                           : (sum8[8] ^ (OP_A[7] ^ bx[7] ^ sum8[7])); // RQ9
  assign ar_half = (OP_A[4] ^ bx[4] ^ sum16[4]) ^ OP_SUB; // RQ13
  // for 16-bit shifts only the low byte counts, so logic and shift kinds both use it
  assign par_even = ~^res[7:0]; // RQ8

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.save_strobe = 1'b0;
    if (setup) begin
      r_d.slverr = !(hit_high || hit_low);
      r_d.rdata  = 32'h0000_0000;
      if (!PWRITE && hit_high) begin
        // reserved low nibble reads as zero
        r_d.rdata[7:0] = {r_q.sw[15:12], 4'h0}; // RQ5
      end
      if (!PWRITE && hit_low) begin
        r_d.rdata[7:0] = r_q.sw[7:0]; // RQ1
      end
    end
    // flag updates from executed instructions
    if (FLAG_UPD) begin
      if (FLAG_AFFECT[stwf_pkg::AFF_CARRY]) begin
        if (FLAG_KIND == stwf_pkg::KIND_ARITH) begin
          r_d.sw[stwf_pkg::BIT_CARRY] = ar_carry; // RQ7
        end else if (FLAG_KIND == stwf_pkg::KIND_SHIFT) begin
          r_d.sw[stwf_pkg::BIT_CARRY] = SHIFT_OUT; // RQ7
        end
      end
      if (FLAG_AFFECT[stwf_pkg::AFF_PV]) begin
        r_d.sw[stwf_pkg::BIT_PV] = (FLAG_KIND == stwf_pkg::KIND_ARITH) ? ar_ovf
                                                                      : par_even; // RQ8
      end
      if (FLAG_AFFECT[stwf_pkg::AFF_HALF] && FLAG_KIND == stwf_pkg::KIND_ARITH) begin
        r_d.sw[stwf_pkg::BIT_HALF] = ar_half; // RQ13
      end
      if (FLAG_AFFECT[stwf_pkg::AFF_ZERO]) begin
        r_d.sw[stwf_pkg::BIT_ZERO] = res_zero; // RQ14
      end
      if (FLAG_AFFECT[stwf_pkg::AFF_SIGN]) begin
        r_d.sw[stwf_pkg::BIT_SIGN] = res_msb; // RQ15
      end
    end
    // single-bit manipulation; load puts a value into the carry accumulator
    case (BIT_OP)
      stwf_pkg::BOP_SET: begin
        r_d.sw[BIT_SEL] = 1'b1; // RQ1
      end
      stwf_pkg::BOP_CLEAR: begin
        r_d.sw[BIT_SEL] = 1'b0; // RQ1
      end
      stwf_pkg::BOP_LOAD: begin
        r_d.sw[stwf_pkg::BIT_CARRY] = BIT_VAL; // RQ7
      end
      default: begin
      end
    endcase
    if (BANK_SEL_EXEC) begin
      r_d.sw[stwf_pkg::BIT_BANK_HI:stwf_pkg::BIT_BANK_LO] = BANK_NUM; // RQ16
    end
    if (EI_EXEC) begin
      r_d.sw[stwf_pkg::BIT_IE] = 1'b1; // RQ12
    end
    if (DI_EXEC) begin
      r_d.sw[stwf_pkg::BIT_IE] = 1'b0; // RQ12
    end
    // saves see the word before this cycle's changes
    if (INT_ACK || BRK_EXEC) begin
      r_d.save_word   = r_q.sw; // RQ2
      r_d.save_strobe = 1'b1;
      r_d.save_to_ctx = 1'b0;
    end else if (CTX_SAVE) begin
      r_d.save_word   = r_q.sw; // RQ3
      r_d.save_strobe = 1'b1;
      r_d.save_to_ctx = 1'b1;
    end
    if (INT_ACK) begin
      r_d.sw[stwf_pkg::BIT_IE] = 1'b0; // RQ12
    end
    // software writes override instruction effects in the same cycle
    if (access && PWRITE && hit_high) begin
      r_d.sw[15:12] = PWDATA[7:4]; // RQ6 RQ17
    end
    if (access && PWRITE && hit_low) begin
      r_d.sw[7:0] = PWDATA[7:0]; // RQ6
    end
    // restores win over everything else
    if (CTX_RESTORE) begin
      r_d.sw = CTX_DATA; // RQ3
    end
    if (POP_VALID) begin
      r_d.sw = POP_DATA; // RQ2
    end
    // reserved bits never hold a one
    r_d.sw = r_d.sw & stwf_pkg::SW_MASK; // RQ5
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r_q <= '0; // RQ4
    end else if (CE) begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign STATUS_WORD = r_q.sw;
  assign SAVE_WORD   = r_q.save_word;
  assign SAVE_STROBE = r_q.save_strobe;
  assign SAVE_TO_CTX = r_q.save_to_ctx;
  assign BANK        = r_q.sw[stwf_pkg::BIT_BANK_HI:stwf_pkg::BIT_BANK_LO]; // RQ16
  assign REGISTER_SET_SELECT         = r_q.sw[stwf_pkg::BIT_RSS];
  assign FLAG_CARRY  = r_q.sw[stwf_pkg::BIT_CARRY]; // RQ22
  assign FLAG_PV     = r_q.sw[stwf_pkg::BIT_PV]; // RQ22
  assign FLAG_ZERO   = r_q.sw[stwf_pkg::BIT_ZERO]; // RQ22
  assign FLAG_SIGN   = r_q.sw[stwf_pkg::BIT_SIGN]; // RQ22
  assign BIT_TEST    = r_q.sw[BIT_SEL]; // RQ1

  // maskable requests need the enable, their own mask clear and priority
  assign INT_ACCEPT  = NMI_REQ || MACRO_REQ // RQ10
                     || (r_q.sw[stwf_pkg::BIT_IE] && MASK_REQ && !MASK_FLAG && PRIO_OK); // RQ11

  // ----------------------------------------------------------------
  // register-set remap of accumulator-style names
  // ----------------------------------------------------------------
  always_comb begin
    REG_NUM = REG_ABS; // RQ20
    if (REMAP_APPLIES) begin
      case (REG_NAME)
        stwf_pkg::NAME_A:  REG_NUM = 4'h1; // RQ18
        stwf_pkg::NAME_X:  REG_NUM = 4'h0;
        stwf_pkg::NAME_B:  REG_NUM = 4'h3;
        stwf_pkg::NAME_C:  REG_NUM = 4'h2;
        stwf_pkg::NAME_AX: REG_NUM = 4'h0;
        stwf_pkg::NAME_BC: REG_NUM = 4'h1;
        default:           REG_NUM = REG_ABS;
      endcase
      if (REGISTER_SET_SELECT && REG_NAME <= stwf_pkg::NAME_C) begin
        REG_NUM = REG_NUM + stwf_pkg::ALT_OFFSET; // RQ19
      end else if (REGISTER_SET_SELECT && REG_NAME <= stwf_pkg::NAME_BC) begin
        REG_NUM = REG_NUM + stwf_pkg::ALT_PAIR_OFS; // RQ19
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic ei_alone;
  assign ei_alone = CE && EI_EXEC && !DI_EXEC && !INT_ACK && !POP_VALID && !CTX_RESTORE
                    && !(access && PWRITE && hit_low) && BIT_OP == 2'h0;

  property p_reset_clear;
    @(posedge CLK) disable iff (!RESETN)
    !$past(RESETN) |-> (STATUS_WORD == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("word not zero after reset"); // RQ4

  property p_ack_clears_ie;
    @(posedge CLK) disable iff (!RESETN)
    (CE && INT_ACK && !POP_VALID && !CTX_RESTORE && !(access && PWRITE && hit_low))
    |=> !STATUS_WORD[3];
  endproperty
  a_ack_clears_ie: assert property (p_ack_clears_ie) else $error("ie kept after ack"); // RQ12

  property p_ei_sets;
    @(posedge CLK) disable iff (!RESETN)
    ei_alone |=> STATUS_WORD[3];
  endproperty
  a_ei_sets: assert property (p_ei_sets) else $error("ie not set by enable"); // RQ12

  property p_push_word;
    @(posedge CLK) disable iff (!RESETN)
    (CE && (INT_ACK || BRK_EXEC)) |=> SAVE_STROBE && !SAVE_TO_CTX
                                     && SAVE_WORD == $past(STATUS_WORD);
  endproperty
  a_push_word: assert property (p_push_word) else $error("push word wrong"); // RQ2

  property p_pop_restore;
    @(posedge CLK) disable iff (!RESETN)
    (CE && POP_VALID) |=> STATUS_WORD == ($past(POP_DATA) & 16'hF0FD);
  endproperty
  a_pop_restore: assert property (p_pop_restore) else $error("pop not restored"); // RQ2

  property p_ctx_restore;
    @(posedge CLK) disable iff (!RESETN)
    (CE && CTX_RESTORE && !POP_VALID) |=> STATUS_WORD == ($past(CTX_DATA) & 16'hF0FD);
  endproperty
  a_ctx_restore: assert property (p_ctx_restore) else $error("context not restored"); // RQ3

  property p_gate_off;
    @(posedge CLK) disable iff (!RESETN)
    (!STATUS_WORD[3] && !NMI_REQ && !MACRO_REQ) |-> !INT_ACCEPT;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("maskable accepted while disabled"); // RQ10

  property p_bit1_zero;
    @(posedge CLK) disable iff (!RESETN)
    STATUS_WORD[1] == 1'b0 && STATUS_WORD[11:8] == 4'h0;
  endproperty
  a_bit1_zero: assert property (p_bit1_zero) else $error("reserved bit set"); // RQ5

  property p_remap_a;
    @(posedge CLK) disable iff (!RESETN)
    (REMAP_APPLIES && REG_NAME == 3'h0) |-> REG_NUM == (REGISTER_SET_SELECT ? 4'h5 : 4'h1);
  endproperty
  a_remap_a: assert property (p_remap_a) else $error("accumulator remap wrong"); // RQ19

  property p_remap_bc;
    @(posedge CLK) disable iff (!RESETN)
    (REMAP_APPLIES && REG_NAME == 3'h5) |-> REG_NUM == (REGISTER_SET_SELECT ? 4'h3 : 4'h1);
  endproperty
  a_remap_bc: assert property (p_remap_bc) else $error("second pair remap wrong"); // RQ18

  property p_bank_load;
    @(posedge CLK) disable iff (!RESETN)
    (CE && BANK_SEL_EXEC && !POP_VALID && !CTX_RESTORE && !(access && PWRITE && hit_high))
    |=> BANK == $past(BANK_NUM);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank not loaded"); // RQ16

  property p_di_clears;
    @(posedge CLK) disable iff (!RESETN)
    (CE && DI_EXEC && !POP_VALID && !CTX_RESTORE && !(access && PWRITE && hit_low))
    |=> !STATUS_WORD[3];
  endproperty
  a_di_clears: assert property (p_di_clears) else $error("ie kept after disable"); // RQ12

  property p_ctx_save;
    @(posedge CLK) disable iff (!RESETN)
    (CE && CTX_SAVE && !INT_ACK && !BRK_EXEC) |=> SAVE_STROBE && SAVE_TO_CTX
                                                 && SAVE_WORD == $past(STATUS_WORD);
  endproperty
  a_ctx_save: assert property (p_ctx_save) else $error("context save wrong"); // RQ3

  c_ack:  cover property (@(posedge CLK) disable iff (!RESETN) CE && INT_ACK);
  c_pop:  cover property (@(posedge CLK) disable iff (!RESETN) CE && POP_VALID);
  c_ctx:  cover property (@(posedge CLK) disable iff (!RESETN) CE && CTX_SAVE ##[1:20] CTX_RESTORE);
  c_wr:   cover property (@(posedge CLK) disable iff (!RESETN) access && PWRITE && hit_low);
  c_bank: cover property (@(posedge CLK) disable iff (!RESETN) CE && BANK_SEL_EXEC);

endmodule

// File: stwf_pkg.sv
// constants and state type for the status word block
package stwf_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_HIGH    = 8'h00;
  localparam logic [7:0]  ADDR_LOW     = 8'h04;

  // ----------------------------------------------------------------
  // field positions inside the 16-bit status word
  // ----------------------------------------------------------------
  localparam int          BIT_USER     = 15;
  localparam int          BIT_BANK_HI  = 14;
  localparam int          BIT_BANK_LO  = 12;
  localparam int          BIT_SIGN     = 7;
  localparam int          BIT_ZERO     = 6;
  localparam int          BIT_RSS      = 5;
  localparam int          BIT_HALF     = 4;
  localparam int          BIT_IE       = 3;
  localparam int          BIT_PV       = 2;
  localparam int          BIT_CARRY    = 0;

  // implemented bits: reserved bits 11-8 and bit 1 stay zero
  localparam logic [15:0] SW_MASK      = 16'hF0FD;
  localparam logic [15:0] SW_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // operation kinds for the flag unit
  // ----------------------------------------------------------------
  localparam logic [1:0]  KIND_ARITH   = 2'h0;
  localparam logic [1:0]  KIND_LOGIC   = 2'h1;
  localparam logic [1:0]  KIND_SHIFT   = 2'h2;

  // affect-mask bit positions
  localparam int          AFF_CARRY    = 0;
  localparam int          AFF_PV       = 1;
  localparam int          AFF_HALF     = 2;
  localparam int          AFF_ZERO     = 3;
  localparam int          AFF_SIGN     = 4;

  // single-bit operations
  localparam logic [1:0]  BOP_SET      = 2'h1;
  localparam logic [1:0]  BOP_CLEAR    = 2'h2;
  localparam logic [1:0]  BOP_LOAD     = 2'h3;

  // accumulator-style operand names
  localparam logic [2:0]  NAME_A       = 3'h0;
  localparam logic [2:0]  NAME_X       = 3'h1;
  localparam logic [2:0]  NAME_B       = 3'h2;
  localparam logic [2:0]  NAME_C       = 3'h3;
  localparam logic [2:0]  NAME_AX      = 3'h4;
  localparam logic [2:0]  NAME_BC      = 3'h5;
  localparam logic [3:0]  ALT_OFFSET   = 4'h4;
  localparam logic [3:0]  ALT_PAIR_OFS = 4'h2;

  // ----------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] sw;
    logic [15:0] save_word;
    logic        save_strobe;
    logic        save_to_ctx;
    logic [31:0] rdata;
    logic        slverr;
  } stwf_state_t;

endpackage

// File: tb_stwf_top.sv
// self-checking bench for the status word block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_stwf_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        CLK = 1'b0, RESETN = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0, FLAG_UPD = 1'b0, OP_WIDE = 1'b0, OP_SUB = 1'b0, OP_CIN = 1'b0;
  logic        SHIFT_OUT = 1'b0, BIT_VAL = 1'b0, EI_EXEC = 1'b0, DI_EXEC = 1'b0;
  logic        BANK_SEL_EXEC = 1'b0, INT_ACK = 1'b0, BRK_EXEC = 1'b0, CTX_SAVE = 1'b0;
  logic        POP_VALID = 1'b0, CTX_RESTORE = 1'b0, NMI_REQ = 1'b0, MACRO_REQ = 1'b0;
  logic        MASK_REQ = 1'b0, MASK_FLAG = 1'b0, PRIO_OK = 1'b0, REMAP_APPLIES = 1'b0;
  logic [1:0]  FLAG_KIND = 2'h0, BIT_OP = 2'h0;
  logic [2:0]  BANK_NUM = 3'h0, REG_NAME = 3'h0;
  logic [3:0]  BIT_SEL = 4'h0, REG_ABS = 4'h0;
  logic [4:0]  FLAG_AFFECT = 5'h00;
  logic [7:0]  PADDR = 8'h00;
  logic [15:0] OP_A = 16'h0000, OP_B = 16'h0000, RESULT_IN = 16'h0000;
  logic [15:0] POP_DATA = 16'h0000, CTX_DATA = 16'h0000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, BIT_TEST, SAVE_STROBE, SAVE_TO_CTX, INT_ACCEPT, REGISTER_SET_SELECT;
  logic        FLAG_CARRY, FLAG_PV, FLAG_ZERO, FLAG_SIGN;
  logic [15:0] SUM_OUT, SAVE_WORD, STATUS_WORD;
  logic [3:0]  REG_NUM;
  logic [2:0]  BANK;
  logic [15:0] m_sw;
  int          n_fail = 0, total_checks = 0;

  always #50 CLK = ~CLK;

  stwf_top stwf_top_i (
    .CLK, .RESETN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .FLAG_UPD, .FLAG_KIND, .FLAG_AFFECT, .OP_WIDE, .OP_SUB, .OP_CIN, .OP_A,
    .OP_B, .RESULT_IN, .SHIFT_OUT, .SUM_OUT, .BIT_OP, .BIT_SEL, .BIT_VAL, .BIT_TEST,
    .EI_EXEC, .DI_EXEC, .BANK_SEL_EXEC, .BANK_NUM, .INT_ACK, .BRK_EXEC, .CTX_SAVE,
    .POP_VALID, .POP_DATA, .CTX_RESTORE, .CTX_DATA, .SAVE_WORD, .SAVE_STROBE,
    .SAVE_TO_CTX, .NMI_REQ, .MACRO_REQ, .MASK_REQ, .MASK_FLAG, .PRIO_OK, .INT_ACCEPT,
    .REMAP_APPLIES, .REG_NAME, .REG_ABS, .REG_NUM, .STATUS_WORD, .BANK, .REGISTER_SET_SELECT,
    .FLAG_CARRY, .FLAG_PV, .FLAG_ZERO, .FLAG_SIGN
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // taking edge: drop pulses, then compare the word and its views
  task automatic tick;
    @(posedge CLK);
    {FLAG_UPD, BIT_OP, EI_EXEC, DI_EXEC, BANK_SEL_EXEC, INT_ACK, BRK_EXEC, CTX_SAVE,
     POP_VALID, CTX_RESTORE} <= '0;
    @(negedge CLK);
    `CHK({STATUS_WORD, BANK, REGISTER_SET_SELECT, FLAG_SIGN, FLAG_ZERO, FLAG_PV, FLAG_CARRY}, {m_sw, m_sw[14:12], m_sw[5], m_sw[7], m_sw[6], m_sw[2], m_sw[0]})
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     input bit stall, output logic [31:0] rd, output logic err);
    int n;
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, wr, addr, wd};
    @(posedge CLK);
    PENABLE <= 1'b1;
    if (stall) CE <= 1'b0;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
      if (stall && n == 1) `CHK(PREADY, 1'b0)
      if (stall && n == 3) CE <= 1'b1;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask

  task automatic reg_rw(input logic [7:0] addr, input logic [31:0] wd, input bit stall);
    logic [31:0] rd;
    logic        err;
    logic        hi;
    logic        lo;
    hi = (addr == stwf_pkg::ADDR_HIGH);
    lo = (addr == stwf_pkg::ADDR_LOW);
    apb(1'b1, addr, wd, stall, rd, err);
    `CHK(err, !(hi | lo))
    if (hi) m_sw[15:12] = wd[7:4];
    if (lo) m_sw[7:0] = wd[7:0] & stwf_pkg::SW_MASK[7:0];
    apb(1'b0, addr, 32'h0000_0000, 1'b0, rd, err);
    `CHK({err, rd}, {!(hi | lo), hi ? {24'h0, m_sw[15:12], 4'h0} : lo ? {24'h0, m_sw[7:0]} : 32'h0})
  endtask

  task automatic ie_exec(input bit en);
    @(posedge CLK);
    {EI_EXEC, DI_EXEC} <= {en, !en};
    m_sw[3] = en;
    tick;
  endtask

  task automatic gate_sweep;
    for (int i = 0; i < 32; i++) begin
      @(posedge CLK);
      {NMI_REQ, MACRO_REQ, MASK_REQ, MASK_FLAG, PRIO_OK} <= 5'(i);
      @(negedge CLK);
      `CHK(INT_ACCEPT, NMI_REQ | MACRO_REQ | (m_sw[3] & MASK_REQ & !MASK_FLAG & PRIO_OK))
    end
  endtask

  // s: 0 acknowledge, 1 break, 2 context save
  task automatic save(input int s);
    logic [15:0] old;
    old = m_sw;
    @(posedge CLK);
    {INT_ACK, BRK_EXEC, CTX_SAVE} <= 3'(3'b100 >> s);
    if (s == 0) m_sw[3] = 1'b0;
    tick;
    `CHK({SAVE_STROBE, SAVE_TO_CTX, SAVE_WORD}, {1'b1, s == 2, old})
    @(negedge CLK);
    `CHK(SAVE_STROBE, 1'b0)
  endtask

  task automatic restore(input bit ctx, input logic [15:0] d);
    @(posedge CLK);
    {POP_VALID, CTX_RESTORE, POP_DATA, CTX_DATA} <= {!ctx, ctx, d, d};
    m_sw = d & stwf_pkg::SW_MASK;
    tick;
  endtask

  task automatic alu(input logic [1:0] k, input logic [4:0] af, input logic wd, sb, ci,
                     input logic [15:0] a, b, res, input logic so);
    int          n, r, c, h, v;
    logic [15:0] m;
    logic [15:0] q;
    n = wd ? 16 : 8;
    m = wd ? 16'hFFFF : 16'h00FF;
    @(posedge CLK);
    {FLAG_UPD, FLAG_KIND, FLAG_AFFECT, OP_WIDE, OP_SUB, OP_CIN} <= {1'b1, k, af, wd, sb, ci};
    {OP_A, OP_B, RESULT_IN, SHIFT_OUT} <= {a, b, res, so};
    r = sb ? int'(a & m) - int'(b & m) - int'(ci) : int'(a & m) + int'(b & m) + int'(ci);
    h = sb ? int'(a[3:0]) < int'(b[3:0]) + int'(ci) : int'(a[3:0]) + int'(b[3:0]) + int'(ci) > 15;
    c = sb ? (r < 0) : (r >> n);
    q = 16'(r) & m;
    v = (sb ? a[n-1] != b[n-1] : a[n-1] == b[n-1]) && q[n-1] != a[n-1];
    if (k == stwf_pkg::KIND_ARITH) begin
      @(negedge CLK);
      `CHK(SUM_OUT, q)
    end else q = res & m;
    if (af[0] && k != stwf_pkg::KIND_LOGIC) m_sw[0] = (k == stwf_pkg::KIND_SHIFT) ? so : c[0];
    if (af[1]) m_sw[2] = (k == stwf_pkg::KIND_ARITH) ? v[0] : ~^q[7:0];
    if (af[2] && k == stwf_pkg::KIND_ARITH) m_sw[4] = h[0];
    if (af[3]) m_sw[6] = (q == 16'h0000);
    if (af[4]) m_sw[7] = q[n-1];
    tick;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    static logic [7:0] adr [6]  = '{8'h00, 8'h04, 8'h08, 8'h04, 8'hFC, 8'h00};
    static logic [3:0] prim [6] = '{4'h1, 4'h0, 4'h3, 4'h2, 4'h0, 4'h1};
    int                seed_ok;
    seed_ok = $urandom(32'hF232);
    m_sw = 16'h0000;
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    tick;
    foreach (adr[i]) reg_rw(adr[i], $urandom(), i == 3);
    for (int b = 0; b < 8; b++) begin
      @(posedge CLK);
      {BANK_SEL_EXEC, BANK_NUM} <= {1'b1, 3'(b)};
      m_sw[14:12] = 3'(b);
      tick;
    end
    repeat (24) begin
      @(posedge CLK);
      {BIT_OP, BIT_SEL, BIT_VAL} <= {2'($urandom_range(3, 1)), 4'($urandom()), 1'($urandom())};
      @(negedge CLK);
      `CHK(BIT_TEST, m_sw[BIT_SEL])
      case (BIT_OP)
        stwf_pkg::BOP_SET:   m_sw = m_sw | (16'h0001 << BIT_SEL) & stwf_pkg::SW_MASK;
        stwf_pkg::BOP_CLEAR: m_sw = m_sw & ~(16'h0001 << BIT_SEL);
        default:             m_sw[0] = BIT_VAL;
      endcase
      tick;
    end
    ie_exec(1'b1);
    gate_sweep;
    save(0);
    gate_sweep;
    ie_exec(1'b1);
    save(1);
    save(2);
    ie_exec(1'b0);
    restore(1'b0, 16'($urandom()));
    restore(1'b1, 16'($urandom()));
    for (int rs = 0; rs < 2; rs++) begin
      reg_rw(stwf_pkg::ADDR_LOW, {24'h0, m_sw[7:6], 1'(rs), m_sw[4:0]}, 1'b0);
      for (int i = 0; i < 12; i++) begin
        @(posedge CLK);
        {REG_NAME, REMAP_APPLIES, REG_ABS} <= {3'(i % 6), i < 6, 4'($urandom())};
        @(negedge CLK);
        `CHK(REG_NUM, REMAP_APPLIES ? prim[REG_NAME] + (m_sw[5] ? (REG_NAME < 4 ? stwf_pkg::ALT_OFFSET : stwf_pkg::ALT_PAIR_OFS) : 4'h0) : REG_ABS)
      end
    end
    reg_rw(stwf_pkg::ADDR_LOW, {24'h0, m_sw[7:6], 1'b0, m_sw[4:0]}, 1'b0);
    repeat (80) alu(2'($urandom_range(2)), 5'($urandom()), 1'($urandom()), 1'($urandom()),
                    1'($urandom()), 16'($urandom()), 16'($urandom()), 16'($urandom()),
                    1'($urandom()));
    close_out;
  end

  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    close_out;
  end
endmodule
